// *** mfr_pkg.sv ***
// shared constants, states and carrier types of the multi-line flash read engine
package mfr_pkg;

  localparam logic [7:0] OP_QUAD_IO       = 8'hEB;
  localparam logic [7:0] OP_QUAD_IO_SHORT = 8'hE7;
  localparam logic [7:0] OP_SET_BURST     = 8'hC0;

  // phase lengths in bits
  localparam logic [4:0] CMD_BITS  = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] WRAP_BITS = 5'h08;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // lane counts per clock
  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;

  // dummy clocks, default select and the three other select codes
  localparam logic [3:0] DUMMY_DUAL       = 4'h4;
  localparam logic [3:0] DUMMY_QUAD_OUT   = 4'h8;
  localparam logic [3:0] DUMMY_QUAD_IO    = 4'h6;
  localparam logic [3:0] DUMMY_QUAD_SHORT = 4'h4;
  localparam logic [3:0] DUMMY_SEL1       = 4'h4;
  localparam logic [3:0] DUMMY_SEL2       = 4'h8;
  localparam logic [3:0] DUMMY_SEL3       = 4'hA;

  // indicator byte is complete on this dummy clock index
  localparam logic [3:0] IND_LAST = 4'h1;

  // wrap code layout
  localparam int         WRAP_OFF_BIT   = 4;
  localparam logic [6:0] WRAP_MIN_DEPTH = 7'h08;

  // reset values
  localparam logic       WRAP_ON_RESET   = 1'b0;
  localparam logic [1:0] WRAP_SEL_RESET  = 2'h0;
  localparam logic       CONT_MODE_RESET = 1'b0;

  typedef enum logic [2:0] {
    ST_START,
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_WRAP,
    ST_IGNORE
  } mfr_state_e;

  typedef struct packed {
    logic       busy;
    logic       fourLine;
    logic       dummySelHigh;
    logic       dummySelLow;
  } mfr_cfg_s;

  typedef struct packed {
    logic       contMode;
    logic       wrapOn;
  } mfr_stat_s;

  typedef struct packed {
    logic        en;
    logic [23:0] addr;
    logic [7:0]  data;
  } mfr_load_s;

endpackage : mfr_pkg

// *** mfr_sync.sv ***
// two-flop level synchroniser
module mfr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule : mfr_sync

// *** mfr_array.sv ***
// byte array: written from the system clock, read asynchronously by the link side
module mfr_array #(
  parameter int ADDR_W = 24
) (
  input  wire logic              clock,
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [7:0]        wrData,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [7:0]        rdData
);

  logic [7:0] mem [0:(2**ADDR_W)-1];

  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // no reset: contents are preloaded before any frame
  assign rdData = mem[rdAddr];

endmodule : mfr_array

// *** mfr_read_engine.sv ***
// read-command engine: dual/quad reads, burst wrap and continuous-read mode
// Summary of operation
// - dual read sends address, dummy and data on two lines; sample rise, drive fall.
// - reads that send an opcode are ignored while a program, erase or status write is busy.
// - start anywhere; address increments per byte and rolls over to zero.
// - quad-output read: opcode and address on one line, 8 dummies, data on four.
// - quad I/O opcode takes 8 single-line or 2 four-line clocks; upper lines ignored.
// - quad I/O address and dummies on four lines, 6 dummies, data until deselect.
// - short-dummy quad I/O read E7h in single-line mode uses 4 dummies.
// - quad I/O dummy count follows the two dummy select bits.
// - wrap is off after reset; reads run linear until a burst length is set.
// - C0h plus one wrap byte sets burst length, in either command mode.
// - codes 00h-03h give 8/16/32/64-byte wrap; code 1xh turns wrap off.
// - wrapping keeps the address inside the aligned block of the first address.
// - wrap stays on until reset or a 1xh code; a new 00h-03h code changes depth.
// - wrap applies to EBh in both modes and E7h in single-line mode.
// - complementary-nibble indicator byte enters continuous-read mode.
// - in continuous-read mode a new frame starts directly with the address.
// - non-complementary indicator then deselect and select leaves continuous-read mode.
// - continuous-read mode only from EBh, never from the dual read.
// - a reset returns to single-line decoding and drops continuous-read mode.
module mfr_read_engine #(
  parameter int         ADDR_W      = 24,
  parameter logic [7:0] OP_DUAL_IO  = 8'hA1,
  parameter logic [7:0] OP_QUAD_OUT = 8'hA2
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              sclk,
  input  wire logic              csN,
  input  wire logic [3:0]        ioIn,
  output logic      [3:0]        ioOut,
  output logic      [3:0]        ioOe,
  input  wire mfr_pkg::mfr_cfg_s  cfgIn,
  input  wire mfr_pkg::mfr_load_s loadIn,
  output mfr_pkg::mfr_stat_s      statOut
);

  // ---------------- functions ----------------

  function automatic logic [2:0] laneCount(
    input mfr_pkg::mfr_state_e st,
    input logic [7:0]          op,
    input logic                fourLine
  );
    logic [2:0] n;
    n = mfr_pkg::LANES_1;
    case (st)
      mfr_pkg::ST_CMD, mfr_pkg::ST_WRAP: begin
        n = fourLine ? mfr_pkg::LANES_4 : mfr_pkg::LANES_1;
      end
      mfr_pkg::ST_ADDR, mfr_pkg::ST_DUMMY: begin
        if (op == OP_DUAL_IO) begin
          n = mfr_pkg::LANES_2;
        end else if (op == OP_QUAD_OUT) begin
          n = mfr_pkg::LANES_1;
        end else begin
          n = mfr_pkg::LANES_4;
        end
      end
      mfr_pkg::ST_DATA: begin
        n = (op == OP_DUAL_IO) ? mfr_pkg::LANES_2 : mfr_pkg::LANES_4;
      end
      default: begin
        n = mfr_pkg::LANES_1;
      end
    endcase
    return n;
  endfunction : laneCount

  function automatic logic [23:0] shiftIn(
    input logic [23:0] old,
    input logic [3:0]  io,
    input logic [2:0]  lanes
  );
    logic [23:0] r;
    r = {old[22:0], io[0]}; // single line: upper lines ignored
    if (lanes == mfr_pkg::LANES_2) begin
      r = {old[21:0], io[1:0]};
    end else if (lanes == mfr_pkg::LANES_4) begin
      r = {old[19:0], io[3:0]};
    end
    return r;
  endfunction : shiftIn

  function automatic logic [3:0] dummyCount(
    input logic [7:0] op,
    input logic [1:0] sel
  );
    logic [3:0] n;
    n = mfr_pkg::DUMMY_QUAD_IO;
    if (op == OP_DUAL_IO) begin
      n = mfr_pkg::DUMMY_DUAL;
    end else if (op == OP_QUAD_OUT) begin
      n = mfr_pkg::DUMMY_QUAD_OUT;
    end else begin
      case (sel)
        2'h0: n = (op == mfr_pkg::OP_QUAD_IO_SHORT) ? mfr_pkg::DUMMY_QUAD_SHORT
                                                    : mfr_pkg::DUMMY_QUAD_IO;
        2'h1: n = mfr_pkg::DUMMY_SEL1;
        2'h2: n = mfr_pkg::DUMMY_SEL2;
        2'h3: n = mfr_pkg::DUMMY_SEL3;
        default: n = mfr_pkg::DUMMY_QUAD_IO;
      endcase
    end
    return n;
  endfunction : dummyCount

  function automatic logic [ADDR_W-1:0] nextAddr(
    input logic [ADDR_W-1:0] a,
    input logic              wrap,
    input logic [1:0]        sel
  );
    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] inc;
    mask = ADDR_W'((mfr_pkg::WRAP_MIN_DEPTH << sel) - 7'h01);
    inc  = a + ADDR_W'(1); // natural rollover to zero
    if (wrap) begin
      return (a & ~mask) | (inc & mask);
    end
    return inc;
  endfunction : nextAddr

  // ---------------- system clock side ----------------

  logic               csSync;
  mfr_pkg::mfr_cfg_s  cfgHold_reg;
  logic               contMode_reg;
  logic               wrapOn_reg;
  logic [1:0]         wrapSel_reg;

  mfr_sync #(
    .WIDTH (1)
  ) u_csSync (
    .clock (clock),
    .rst_n (rst_n),
    .din   (csN),
    .dout  (csSync)
  );

  // config is frozen while selected, so the link side reads a stable word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfgHold_reg <= '0;
    end else if (csSync) begin
      cfgHold_reg <= cfgIn;
    end
  end

  mfr_sync #(
    .WIDTH (2)
  ) u_statSync (
    .clock (clock),
    .rst_n (rst_n),
    .din   ({contMode_reg, wrapOn_reg}),
    .dout  (statOut)
  );

  // ---------------- link side ----------------

  logic                frameRst_n;
  mfr_pkg::mfr_state_e state_reg;
  mfr_pkg::mfr_state_e curState;
  logic [7:0]          cmd_reg;
  logic [7:0]          curCmd;
  logic [23:0]         shift_reg;
  logic [23:0]         shiftNext;
  logic [4:0]          bitCnt_reg;
  logic [4:0]          bitsNext;
  logic [4:0]          phaseBits;
  logic                phaseDone;
  logic [2:0]          lanes;
  logic [3:0]          dummyCnt_reg;
  logic [3:0]          dummyNeed;
  logic [3:0]          outIdx_reg;
  logic [ADDR_W-1:0]   addr_reg;
  logic [7:0]          memByte;
  logic [7:0]          opNext;
  logic                isRead;
  logic                modeOk;
  logic                wrapApplies;
  logic                indDone;
  logic [7:0]          outShift;
  logic [2:0]          outLanes;

  // deselect clears all per-frame state, since the link clock stops between frames
  assign frameRst_n = rst_n & ~csN;

  // a frame in continuous-read mode skips the opcode
  assign curState = (state_reg == mfr_pkg::ST_START)
                  ? (contMode_reg ? mfr_pkg::ST_ADDR : mfr_pkg::ST_CMD)
                  : state_reg;
  assign curCmd   = (state_reg == mfr_pkg::ST_START && contMode_reg) ? mfr_pkg::OP_QUAD_IO
                                                                     : cmd_reg;

  assign lanes     = laneCount(curState, curCmd, cfgHold_reg.fourLine);
  assign shiftNext = shiftIn(shift_reg, ioIn, lanes);
  assign bitsNext  = bitCnt_reg + {2'h0, lanes};
  assign phaseBits = (curState == mfr_pkg::ST_ADDR) ? mfr_pkg::ADDR_BITS
                   : (curState == mfr_pkg::ST_WRAP) ? mfr_pkg::WRAP_BITS
                   : mfr_pkg::CMD_BITS;
  assign phaseDone = (bitsNext == phaseBits);
  assign dummyNeed = dummyCount(cmd_reg, {cfgHold_reg.dummySelHigh, cfgHold_reg.dummySelLow});

  assign opNext = shiftNext[7:0];
  assign isRead = (opNext == OP_DUAL_IO) || (opNext == OP_QUAD_OUT)
               || (opNext == mfr_pkg::OP_QUAD_IO) || (opNext == mfr_pkg::OP_QUAD_IO_SHORT);
  // in four-line command mode only EBh is a valid read
  assign modeOk = !cfgHold_reg.fourLine || (opNext == mfr_pkg::OP_QUAD_IO);

  assign wrapApplies = wrapOn_reg && ((cmd_reg == mfr_pkg::OP_QUAD_IO)
                    || (cmd_reg == mfr_pkg::OP_QUAD_IO_SHORT));

  // indicator is the first two four-line dummy clocks of EBh
  assign indDone = (curState == mfr_pkg::ST_DUMMY) && (cmd_reg == mfr_pkg::OP_QUAD_IO)
                && (dummyCnt_reg == mfr_pkg::IND_LAST);

  // frame sequencer, sampling on the rising link edge
  always_ff @(posedge sclk or negedge frameRst_n) begin
    if (!frameRst_n) begin
      state_reg    <= mfr_pkg::ST_START;
      cmd_reg      <= '0;
      shift_reg    <= '0;
      bitCnt_reg   <= '0;
      dummyCnt_reg <= '0;
      outIdx_reg   <= '0;
      addr_reg     <= '0;
    end else begin
      case (curState)
        mfr_pkg::ST_CMD: begin
          shift_reg <= shiftNext;
          if (phaseDone) begin
            bitCnt_reg <= '0;
            cmd_reg    <= opNext;
            if (opNext == mfr_pkg::OP_SET_BURST) begin
              state_reg <= mfr_pkg::ST_WRAP;
            end else if (isRead && modeOk && !cfgHold_reg.busy) begin
              state_reg <= mfr_pkg::ST_ADDR;
            end else begin
              state_reg <= mfr_pkg::ST_IGNORE;
            end
          end else begin
            bitCnt_reg <= bitsNext;
            state_reg  <= mfr_pkg::ST_CMD;
          end
        end
        mfr_pkg::ST_ADDR: begin
          cmd_reg   <= curCmd;
          shift_reg <= shiftNext;
          if (phaseDone) begin
            bitCnt_reg   <= '0;
            addr_reg     <= shiftNext[ADDR_W-1:0]; // any start byte
            dummyCnt_reg <= '0;
            state_reg    <= mfr_pkg::ST_DUMMY;
          end else begin
            bitCnt_reg <= bitsNext;
            state_reg  <= mfr_pkg::ST_ADDR;
          end
        end
        mfr_pkg::ST_DUMMY: begin
          shift_reg    <= shiftNext;
          dummyCnt_reg <= dummyCnt_reg + 4'h1;
          if (dummyCnt_reg + 4'h1 == dummyNeed) begin
            outIdx_reg <= '0;
            state_reg  <= mfr_pkg::ST_DATA;
          end
        end
        mfr_pkg::ST_DATA: begin
          // stream until deselect
          if (outIdx_reg + {1'b0, lanes} == mfr_pkg::BYTE_BITS) begin
            outIdx_reg <= '0;
            addr_reg   <= nextAddr(addr_reg, wrapApplies, wrapSel_reg);
          end else begin
            outIdx_reg <= outIdx_reg + {1'b0, lanes};
          end
        end
        mfr_pkg::ST_WRAP: begin
          shift_reg <= shiftNext;
          if (phaseDone) begin
            bitCnt_reg <= '0;
            state_reg  <= mfr_pkg::ST_IGNORE;
          end else begin
            bitCnt_reg <= bitsNext;
          end
        end
        mfr_pkg::ST_IGNORE: begin
          state_reg <= mfr_pkg::ST_IGNORE;
        end
        default: begin
          state_reg <= mfr_pkg::ST_IGNORE;
        end
      endcase
    end
  end

  // continuous-read mode persists across frames; only reset clears it outright
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      contMode_reg <= mfr_pkg::CONT_MODE_RESET;
    end else if (indDone && frameRst_n) begin
      // takes effect at the next select
      contMode_reg <= (shiftNext[7:4] == ~shiftNext[3:0]);
    end
  end

  // burst wrap setting
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      wrapOn_reg  <= mfr_pkg::WRAP_ON_RESET;
      wrapSel_reg <= mfr_pkg::WRAP_SEL_RESET;
    end else if (frameRst_n && curState == mfr_pkg::ST_WRAP && phaseDone) begin
      if (shiftNext[mfr_pkg::WRAP_OFF_BIT]) begin
        wrapOn_reg <= 1'b0;
      end else if (shiftNext[7:2] == 6'h00) begin
        wrapOn_reg  <= 1'b1;
        wrapSel_reg <= shiftNext[1:0];
      end
    end
  end

  mfr_array #(
    .ADDR_W (ADDR_W)
  ) u_array (
    .clock  (clock),
    .wrEn   (loadIn.en),
    .wrAddr (loadIn.addr[ADDR_W-1:0]),
    .wrData (loadIn.data),
    .rdAddr (addr_reg),
    .rdData (memByte)
  );

  assign outLanes = laneCount(mfr_pkg::ST_DATA, cmd_reg, cfgHold_reg.fourLine);
  assign outShift = memByte << outIdx_reg;

  // data driven on the falling link edge, msb first
  always_ff @(negedge sclk or negedge frameRst_n) begin
    if (!frameRst_n) begin
      ioOut <= '0;
      ioOe  <= '0;
    end else if (state_reg == mfr_pkg::ST_DATA) begin
      if (outLanes == mfr_pkg::LANES_2) begin
        ioOut <= {2'h0, outShift[7:6]};
        ioOe  <= 4'h3;
      end else begin
        ioOut <= outShift[7:4];
        ioOe  <= 4'hF;
      end
    end else begin
      ioOut <= '0;
      ioOe  <= '0;
    end
  end

endmodule : mfr_read_engine

// *** mfr_read_engine_sva.sv ***
// concurrent checks on the ports of the read engine
module mfr_read_engine_sva #(
  parameter int ADDR_W = 24
) (
  input wire logic               clock,
  input wire logic               rst_n,
  input wire logic               sclk,
  input wire logic               csN,
  input wire logic [3:0]         ioOut,
  input wire logic [3:0]         ioOe,
  input wire mfr_pkg::mfr_cfg_s  cfgIn,
  input wire mfr_pkg::mfr_stat_s statOut
);
  logic busyFrame;

  // a frame opened with busy held long enough for the snapshot to see it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) busyFrame <= 1'b0;
    else if (csN) busyFrame <= 1'b0;
    else if ($fell(csN)) busyFrame <= cfgIn.busy && $past(cfgIn.busy, 3);
  end

  sequence dataOn;
    (ioOe != 4'h0) ##1 !csN;
  endsequence

  sequence oeStart;
    $rose(ioOe != 4'h0);
  endsequence

  AST_OE_DESELECT: assert property (@(posedge clock) disable iff (!rst_n)
    csN |-> ioOe == 4'h0) else $error("output enable while deselected");
  AST_OE_WIDTH: assert property (@(posedge clock) disable iff (!rst_n)
    ioOe inside {4'h0, 4'h3, 4'hF}) else $error("output enable lane set wrong");
  AST_BUSY_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
    busyFrame |-> ioOe == 4'h0) else $error("read answered while busy");
  AST_STAT_RESET: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> (statOut == 2'h0) [*2]) else $error("status not clear after reset");
  AST_OUT_ON_FALL: assert property (@(posedge clock) disable iff (!rst_n)
    !csN && !$past(csN) && $changed(ioOut) |-> !sclk) else $error("data moved off falling edge");
  AST_OE_ON_FALL: assert property (@(posedge clock) disable iff (!rst_n)
    oeStart |-> !sclk && !csN) else $error("output enable rose off falling edge");
  AST_OE_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    dataOn |-> $stable(ioOe)) else $error("data lanes dropped before deselect");
  AST_CONT_IN_FRAME: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(statOut.contMode) |-> !$past(csN, 3)) else $error("continuous mode set outside frame");
endmodule : mfr_read_engine_sva

bind mfr_read_engine mfr_read_engine_sva #(.ADDR_W(ADDR_W)) i_sva (
  .clock(clock), .rst_n(rst_n), .sclk(sclk), .csN(csN), .ioOut(ioOut),
  .ioOe(ioOe), .cfgIn(cfgIn), .statOut(statOut));

// *** mfr_host.sv ***
// host controller model on the far side of the serial link
module mfr_host (
  output logic            sclk,
  output logic            csN,
  output logic      [3:0] ioIn,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] drv;
  logic [3:0] hostOe;
  logic [7:0] got [16];

  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    drv = 4'h0;
    hostOe = 4'h0;
  end

  // released lines are pulled up, as the reset by all ones needs
  always_comb begin
    for (int i = 0; i < 4; i++) ioIn[i] = ioOe[i] ? ioOut[i] : (hostOe[i] ? drv[i] : 1'b1);
  end

  // sclk stands low outside frames
  task automatic tick;
    #16 sclk = 1'b1;
    #16 sclk = 1'b0;
  endtask : tick

  task automatic send(input logic [31:0] v, input int n, input int lanes);
    logic [31:0] s;
    s = v << (32 - n * lanes);
    for (int c = 0; c < n; c++) begin
      hostOe = 4'hF;
      drv = 4'(s[31:28] >> (4 - lanes));
      if (lanes == 1) drv[3:1] = {3{~s[31]}};
      s = s << lanes;
      tick();
    end
  endtask : send

  task automatic get(input int n, input int lanes);
    logic [7:0] b;
    for (int k = 0; k < n; k++) begin
      b = 8'h00;
      hostOe = 4'h0;
      repeat (8 / lanes) begin
        #16 sclk = 1'b1;
        b = 8'((b << lanes) | (ioIn & 4'((1 << lanes) - 1)));
        #16 sclk = 1'b0;
      end
      got[k] = b;
    end
  endtask : get

  // quad enable is the host's duty and is taken as already set
  task automatic frame(input logic [7:0] op, input int opL, input logic [23:0] a, input int aL,
                       input int indL, input logic [7:0] ind, input int dum, input int dL,
                       input int n);
    #1.3 csN = 1'b0;
    if (opL > 0) send(32'(op), 8 / opL, opL);
    send(32'(a), 24 / aL, aL);
    if (indL > 0) send(32'(ind), 8 / indL, indL);
    hostOe = 4'h0;
    repeat (dum) tick();
    get(n, dL);
    #16 csN = 1'b1;
  endtask : frame

  task automatic burst(input logic [7:0] code, input int lanes);
    #1.3 csN = 1'b0;
    send(32'(mfr_pkg::OP_SET_BURST), 8 / lanes, lanes);
    send(32'(code), 8 / lanes, lanes);
    #16 csN = 1'b1;
    hostOe = 4'h0;
  endtask : burst

  task automatic cont_reset;
    #1.3 csN = 1'b0;
    send(32'hFFFFFFFF, 8, 4);
    #16 csN = 1'b1;
    hostOe = 4'h0;
  endtask : cont_reset
endmodule : mfr_host

// *** mfr_read_engine_tb.sv ***
// self-checking bench of the read engine driven by the host link model
module mfr_read_engine_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] OPD = 8'hA1;
  localparam logic [7:0] OPQ = 8'hA2;
  localparam logic [7:0] EB  = mfr_pkg::OP_QUAD_IO;
  localparam logic [7:0] E7  = mfr_pkg::OP_QUAD_IO_SHORT;
  logic               clock;
  logic               rst_n;
  logic               sclk;
  logic               csN;
  logic [3:0]         ioIn;
  logic [3:0]         ioOut;
  logic [3:0]         ioOe;
  mfr_pkg::mfr_cfg_s  cfg;
  mfr_pkg::mfr_load_s load;
  mfr_pkg::mfr_stat_s stat;
  int                 mismatches;
  int                 checked;
  int                 cycles;

  mfr_read_engine #(.ADDR_W(12), .OP_DUAL_IO(OPD), .OP_QUAD_OUT(OPQ)) i_dut (
    .clock(clock), .rst_n(rst_n), .sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut),
    .ioOe(ioOe), .cfgIn(cfg), .loadIn(load), .statOut(stat));
  mfr_host i_host (.sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));

  always #2 clock = ~clock;

  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      test_done();
    end
  end

  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction : pat

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  // the snapshot needs a settled config before the next frame opens
  task automatic setcfg(input logic [3:0] c);
    cfg = c;
    step(4);
  endtask : setcfg

  task automatic rd(input logic [7:0] op, input int opL, input logic [23:0] a, input int aL,
                    input int indL, input logic [7:0] ind, input int dum, input int dL,
                    input int n, input int depth);
    logic [11:0] e;
    e = a[11:0];
    i_host.frame(op, opL, a, aL, indL, ind, dum, dL, n);
    for (int k = 0; k < n; k++) begin
      check("data", i_host.got[k], pat(e));
      if (depth > 0) e = (e & ~12'(depth - 1)) | ((e + 12'h1) & 12'(depth - 1));
      else e = e + 12'h1;
    end
    step(4);
  endtask : rd

  task automatic t_dual;
    rd(OPD, 1, 24'h000FFE, 2, 2, 8'hA5, 0, 2, 4, 0);
    check("contMode", 8'(stat.contMode), 8'h00);
    rd(OPQ, 1, 24'h000123, 1, 0, 8'h00, 8, 4, 3, 0);
    $display("test dual and quad output done");
  endtask : t_dual

  task automatic t_sel;
    int dq[4] = '{6, 4, 8, 10};
    int ds[4] = '{4, 4, 8, 10};
    for (int s = 0; s < 4; s++) begin
      setcfg(4'(s));
      rd(EB, 1, 24'(12'h200 + s), 4, 4, 8'hFF, dq[s] - 2, 4, 2, 0);
      rd(E7, 1, 24'(12'h300 + s), 4, 0, 8'h00, ds[s], 4, 2, 0);
    end
    setcfg(4'h4);
    rd(EB, 4, 24'h000345, 4, 4, 8'h00, 4, 4, 2, 0);
    $display("test quad io done");
  endtask : t_sel

  task automatic t_wrap;
    setcfg(4'h0);
    rd(EB, 1, 24'h000007, 4, 4, 8'hFF, 4, 4, 2, 0);
    for (int c = 0; c < 4; c++) begin
      i_host.burst(8'(c), 1);
      step(4);
      check("wrapOn", 8'(stat.wrapOn), 8'h01);
      rd(EB, 1, 24'((8 << c) * 3 - 2), 4, 4, 8'hFF, 4, 4, 3, 8 << c);
    end
    rd(E7, 1, 24'h00005E, 4, 0, 8'h00, 4, 4, 3, 64);
    setcfg(4'h4);
    i_host.burst(8'h00, 4);
    rd(EB, 4, 24'h000016, 4, 4, 8'h00, 4, 4, 3, 8);
    setcfg(4'h0);
    i_host.burst(8'h1A, 1);
    step(4);
    check("wrapOn", 8'(stat.wrapOn), 8'h00);
    rd(EB, 1, 24'h000007, 4, 4, 8'hFF, 4, 4, 2, 0);
    $display("test burst wrap done");
  endtask : t_wrap

  task automatic t_cont;
    logic [7:0] on [4] = '{8'hA5, 8'h5A, 8'hF0, 8'h0F};
    logic [7:0] off [4] = '{8'hFF, 8'h00, 8'hAA, 8'h55};
    for (int i = 0; i < 4; i++) begin
      rd(EB, 1, 24'h000010, 4, 4, on[i], 4, 4, 1, 0);
      check("contMode", 8'(stat.contMode), 8'h01);
      rd(EB, 0, 24'h000020, 4, 4, on[i], 4, 4, 2, 0);
      rd(EB, 0, 24'h000030, 4, 4, off[i], 4, 4, 2, 0);
      check("contMode", 8'(stat.contMode), 8'h00);
      rd(EB, 1, 24'h000040, 4, 4, 8'hFF, 4, 4, 1, 0);
    end
    rd(EB, 1, 24'h000050, 4, 4, 8'hA5, 4, 4, 1, 0);
    i_host.cont_reset();
    step(4);
    check("contMode", 8'(stat.contMode), 8'h00);
    i_host.burst(8'h00, 1);
    rd(EB, 1, 24'h000060, 4, 4, 8'hA5, 4, 4, 1, 0);
    check("statOut", 8'(stat), 8'h03);
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    step(4);
    check("statOut", 8'(stat), 8'h00);
    rd(EB, 1, 24'h000067, 4, 4, 8'hFF, 4, 4, 2, 0);
    $display("test continuous mode done");
  endtask : t_cont

  task automatic t_busy;
    setcfg(4'h8);
    i_host.frame(EB, 1, 24'h000345, 4, 4, 8'hFF, 4, 4, 1);
    check("busy data", i_host.got[0], 8'hFF);
    // short-dummy read is single-line only: refused in four-line mode, lines stay released
    setcfg(4'h4);
    i_host.frame(E7, 4, 24'h000345, 4, 0, 8'h00, 4, 4, 1);
    check("refused data", i_host.got[0], 8'hFF);
    setcfg(4'h0);
    rd(EB, 1, 24'h000345, 4, 4, 8'hFF, 4, 4, 1, 0);
    $display("test busy done");
  endtask : t_busy

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    cfg = 4'h0;
    load = '0;
    mismatches = 0;
    checked = 0;
    cycles = 0;
    step(8);
    rst_n = 1'b1;
    step(4);
    // the whole shrunken array is filled, so every read below meets known data
    for (int k = 0; k < 4096; k++) begin
      load = '{1'b1, 24'(k), pat(12'(k))};
      step(1);
    end
    load = '0;
    step(4);
    t_dual();
    t_sel();
    t_wrap();
    t_cont();
    t_busy();
    test_done();
  end
endmodule : mfr_read_engine_tb
